/* verif/tb_uaux_channel.sv */
// Self-checking bench for the auxiliary logic of one serial channel.
// Assumes the channel is alone, so the other channels report ready to sleep.
`timescale 1ns/10ps
`default_nettype none
module tb_uaux_channel;
  import uaux_pkg::*;
  typedef struct {logic [7:0] line_control; logic [2:0] a; logic [7:0] d;} uaux_row_s;
  logic       clk, rst_n, sel, rd, wr, valid, tick, bstart, tbit, send, others, ir, trig;
  logic       rxp, txp, rts_n, dtr_n, intr, sok, osc, push, rxs, hrd, ld, psend;
  logic [2:0] addr;
  logic [7:0] wdata, rchar, rdata, txd, fifo_d;
  logic [3:0] modem_n;
  int         num_errors, n_checks;
  // Ordinary register cases: bank key, offset, byte written and read back.
  uaux_row_s  rows[6] = '{'{8'h03, 3'h7, 8'ha5}, '{8'h80, 3'h0, 8'h11},
    '{8'h80, 3'h1, 8'h22}, '{8'h80, 3'h2, 8'h0d}, '{8'hbf, 3'h4, 8'h44}, '{8'hbf, 3'h7, 8'h15}};

  // ==========================================================================
  // Design and partner
  uaux_channel dut (.core_clk_i(clk), .reset_n_i(rst_n), .chan_sel_i(sel), .reg_addr_i(addr),
    .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .rx_holding_i(8'h3c), .line_status_i(8'h60), .core_isr_i(4'h1), .rx_holding_rd_o(hrd),
    .tx_holding_ld_o(ld), .tx_holding_data_o(txd), .rx_char_valid_i(valid), .rx_char_i(rchar),
    .rx_fifo_push_o(push), .rx_fifo_data_o(fifo_d), .rx_trigger_i(trig), .pause_send_o(psend),
    .tick16_i(tick), .tx_bit_start_i(bstart), .tx_shift_bit_i(tbit), .rx_serial_o(rxs),
    .rx_pin_i(rxp), .tx_pin_o(txp), .cts_n_i(modem_n[0]), .dsr_n_i(modem_n[1]),
    .carrier_detect_in_n_i(modem_n[2]), .ring_indicator_in_n_i(modem_n[3]), .rts_n_o(rts_n),
    .dtr_n_o(dtr_n), .intr_o(intr), .sleep_ok_o(sok), .others_sleep_ok_i(others),
    .osc_run_o(osc));
  uaux_remote remote (.send_i(send), .ir_i(ir), .tx_pin_i(txp), .rx_pin_o(rxp),
    .modem_n_o(modem_n));

  // ==========================================================================
  // Clock, bus cycles and comparisons
  always #10 clk = ~clk;

  // One access; strobes drop after the sampling edge so tasks may run back to back.
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    sel <= 1'b1;
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    chk8(n, {7'h0, e}, {7'h0, g});
  endtask

  // A received character; the push shows one cycle after the strobe.
  task automatic rx_char(input logic [7:0] c);
    @(posedge clk);
    valid <= 1'b1;
    rchar <= c;
    @(posedge clk);
    valid <= 1'b0;
    #1;
  endtask

  task automatic results;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    #100000;
    num_errors++;
    results();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {clk, rst_n, sel, rd, wr, valid, tick, bstart, send, ir, trig} = '0;
    {tbit, others, addr, wdata, rchar} = {2'b11, 19'h0};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, OFS_LCR, rows[i].line_control);
      bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 8'h00);
      chk8("reg_rw", rows[i].d, rdata);
    end
    bus(1'b1, OFS_LCR, 8'h03);
    bus(1'b1, OFS_DATA, 8'h5a);
    chk8("tx_holding", 8'h5a, txd);
    chk1("tx_load", 1'b1, ld);
    bus(1'b0, OFS_DATA, 8'h00);
    chk8("rx_holding", 8'h3c, rdata);
    chk1("rx_read", 1'b1, hrd);
    // Special character with 7-bit words: bit 7 differs yet still matches.
    bus(1'b1, OFS_LCR, 8'hbf);
    bus(1'b1, OFS_ISR, 8'h20);
    bus(1'b1, OFS_LCR, 8'h02);
    bus(1'b1, OFS_IER, 8'h20);
    rx_char(8'h95);
    chk1("push", 1'b1, push);
    chk8("fifo_data", 8'h95, fifo_d);
    chk1("intr", 1'b1, intr);
    bus(1'b0, OFS_ISR, 8'h00);
    chk1("isr_special", 1'b1, rdata[ISR_SPEC_BIT]);
    // Only the least significant bit differs, so no detection.
    rx_char(8'h14);
    chk1("intr_nomatch", 1'b0, intr);
    // Infrared: a zero bit gives a short high pulse, a one bit none.
    ir <= 1'b1;
    bus(1'b1, OFS_MCR, 8'h40);
    chk1("ir_idle", 1'b0, txp);
    chk1("ir_rx_idle", 1'b1, rxs);
    tick <= 1'b1;
    tbit <= 1'b0;
    bstart <= 1'b1;
    @(posedge clk);
    bstart <= 1'b0;
    @(posedge clk);
    #1;
    chk1("ir_pulse", 1'b1, txp);
    repeat (4) @(posedge clk);
    #1;
    chk1("ir_pulse_end", 1'b0, txp);
    send <= 1'b1;
    @(posedge clk);
    #1;
    chk1("ir_rx_zero", 1'b0, rxs);
    send <= 1'b0;
    ir <= 1'b0;
    tbit <= 1'b1;
    // Loopback masks the modem outputs and returns the shifter output.
    bus(1'b1, OFS_MCR, 8'h13);
    tbit <= 1'b0;
    #1;
    chk1("loop_tx", 1'b1, txp);
    chk1("loop_rts", 1'b1, rts_n & dtr_n);
    chk1("loop_rx", 1'b0, rxs);
    bus(1'b1, OFS_MCR, 8'h03);
    chk1("rts_on", 1'b0, rts_n);
    // Sleep, wake on a start bit, then sleep disabled by the host.
    tbit <= 1'b1;
    bus(1'b1, OFS_MCR, 8'h00);
    bus(1'b1, OFS_IER, 8'h10);
    bus(1'b0, OFS_MSR, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    chk1("asleep", 1'b0, osc);
    chk1("sleep_ok", 1'b1, sok);
    send <= 1'b1;
    @(posedge clk);
    #1;
    chk1("wake", 1'b1, osc);
    send <= 1'b0;
    bus(1'b1, OFS_IER, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    chk1("sleep_off", 1'b1, osc);
    chk1("sleep_ok_off", 1'b0, sok);
    // Pause after two 10-bit frames of 16 ticks, plus the load and send edges.
    bus(1'b1, OFS_LCR, 8'hbf);
    bus(1'b1, OFS_ISR, 8'h08);
    bus(1'b1, OFS_LCR, 8'h03);
    trig <= 1'b1;
    repeat (PAUSE_CHARS * 160 + 1) @(posedge clk);
    #1;
    chk1("pause_early", 1'b0, psend);
    @(posedge clk);
    #1;
    chk1("pause_sent", 1'b1, psend);
    results();
  end
endmodule
`default_nettype wire

/* verif/uaux_remote.sv */
// Remote serial unit model facing the line pins of one channel.
// Assumes the bench raises send_i to ask for a start bit.
`timescale 1ns/10ps
`default_nettype none
module uaux_remote (
  input  wire logic  send_i,
  input  wire logic  ir_i,
  input  wire logic  tx_pin_i,
  output logic       rx_pin_o,
  output logic [3:0] modem_n_o
);
  // ==========================================================================
  // Line side
  // A wired line idles at mark, so leaving loopback never looks like a break;
  // an infrared transceiver idles dark and lights up only for a pulse.
  assign rx_pin_o  = ir_i ? send_i : !send_i;
  // Modem lines stay steady, so only loopback sets change flags for the host to clear.
  assign modem_n_o = 4'hf;
endmodule
`default_nettype wire

/* verilog/uaux_channel.sv */
// Auxiliary logic of one channel of a multi-channel serial controller.
// Assumes the receiver, transmitter, FIFOs and baud generator sit outside,
// and that other channels report their readiness for sleep.
`timescale 1ns/10ps
`default_nettype none
// How it works
// RULE1: With special-character enable set, each received character is compared to pause_char_2.
// RULE2: A match still stores the character and sets interrupt status bit 4.
// RULE3: Compared bits equal the word length set by line control bits 0-1.
// RULE4: Stored character bit 0 is compared with the received character's LSB.
// RULE5: Infrared encoder sends a 3/16-bit high pulse for each zero bit.
// RULE6: Infrared codec works only while modem control bit 6 is one.
// RULE7: In infrared mode transmit idles low and receive treats low as idle.
// RULE8: Sleep needs no pending interrupt and sleep enable set on every channel.
// RULE9: Sleep also needs clear modem change flags and receive inputs idling high.
// RULE10: While asleep the oscillator is halted.
// RULE11: Wake on receive start bit, transmit holding write, or modem input change.
// RULE12: Return to sleep once serviced; never sleep with an interrupt pending.
// RULE13: Host reads modem status to clear modem change flags before sleeping again.
// RULE14: Sleep stays enabled until the host clears interrupt enable bit 4.
// RULE15: Loopback is on while modem control bit 4 is one.
// RULE16: In loopback the transmit shift output feeds the receive input.
// RULE17: In loopback transmit pin is high, modem outputs off, modem inputs ignored.
// RULE18: Outside party keeps receive input high during loopback to avoid false break.
// RULE19: Offset 0 reads receive holding, writes transmit holding while line control bit 7 is zero.
// RULE20: With bit 7 set and not 0xBF, offsets 0-2 reach the divisor registers.
// RULE21: With 0xBF, offset 2 is enhanced_feature and offsets 4-7 the flow characters.
// RULE22: Receive trigger with software flow control sends pause after two character times.
// RULE23: Special-character flag drives the interrupt only with interrupt enable bit 5.
// RULE24: Infrared decoder turns a pulse in the bit into zero, no pulse into one.
module uaux_channel
  import uaux_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       reset_n_i,
  // Host register port.
  input  wire logic       chan_sel_i,
  input  wire logic [2:0] reg_addr_i,
  input  wire logic       reg_rd_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic [7:0]      reg_rdata_o,
  // Rest of the channel.
  input  wire logic [7:0] rx_holding_i,
  input  wire logic [7:0] line_status_i,
  input  wire logic [3:0] core_isr_i,
  output logic            rx_holding_rd_o,
  output logic            tx_holding_ld_o,
  output logic [7:0]      tx_holding_data_o,
  input  wire logic       rx_char_valid_i,
  input  wire logic [7:0] rx_char_i,
  output logic            rx_fifo_push_o,
  output logic [7:0]      rx_fifo_data_o,
  input  wire logic       rx_trigger_i,
  output logic            pause_send_o,
  input  wire logic       tick16_i,
  input  wire logic       tx_bit_start_i,
  input  wire logic       tx_shift_bit_i,
  output logic            rx_serial_o,
  // Line pins.
  input  wire logic       rx_pin_i,
  output logic            tx_pin_o,
  input  wire logic       cts_n_i,
  input  wire logic       dsr_n_i,
  input  wire logic       carrier_detect_in_n_i,
  input  wire logic       ring_indicator_in_n_i,
  output logic            rts_n_o,
  output logic            dtr_n_o,
  // Interrupt and sleep.
  output logic            intr_o,
  output logic            sleep_ok_o,
  input  wire logic       others_sleep_ok_i,
  output logic            osc_run_o
);

  typedef struct packed {
    logic [7:0]  line_control;
    logic [7:0]  interrupt_enable;
    logic [7:0]  modem_control;
    logic [7:0]  enhanced_feature;
    logic [7:0]  fifo_control;
    logic [7:0]  dll;
    logic [7:0]  divisor_high;
    logic [7:0]  divisor_fraction;
    logic [7:0]  scratch_pad;
    logic [7:0]  xon1;
    logic [7:0]  xon2;
    logic [7:0]  xoff1;
    logic [7:0]  xoff2;
    logic        spec_flag;
    logic [3:0]  msr_delta;
    logic [3:0]  modem_prev;
    logic        asleep;
    uaux_pause_e pause_st;
    logic [8:0]  pause_cnt;
    logic        pause_send;
    logic [7:0]  rdata;
    logic        rhr_rd;
    logic        thr_ld;
    logic [7:0]  thr_data;
    logic        push;
    logic [7:0]  push_data;
  } uaux_chan_s;

  uaux_chan_s st_r;
  uaux_chan_s st_nxt;

  uaux_ir_if ir_bus ();
  logic       spec_match;
  logic       loop_on;
  logic       enh_bank;
  logic       div_bank;
  logic       rd_hit;
  logic       wr_hit;
  logic [3:0] modem_now;
  logic       modem_int;
  logic       pending;
  logic       wake;
  logic [7:0] isr_val;

  // ==========================================================================
  // Submodules.
  uaux_ir_codec u_ir (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .ir         (ir_bus.codec)
  );

  uaux_char_match #(.W(8)) u_spec (
    .rx_char_i  (rx_char_i),
    .stored_i   (st_r.xoff2),
    .word_len_i (st_r.line_control[1:0]),
    .match_o    (spec_match)
  );

  // ==========================================================================
  // Bank selection and mode decode.
  assign enh_bank = (st_r.line_control == LCR_ENH_KEY);  // RULE21
  assign div_bank = st_r.line_control[LCR_DIV_BIT] && !enh_bank;  // RULE20
  assign rd_hit   = chan_sel_i && reg_rd_i;
  assign wr_hit   = chan_sel_i && reg_wr_i;
  assign loop_on  = st_r.modem_control[MCR_LOOP_BIT];  // RULE15

  // Modem status in asserted polarity: cd, ri, dsr, cts. Loopback feeds
  // the modem control outputs back and ignores the pins.
  assign modem_now = loop_on ? {st_r.modem_control[3], st_r.modem_control[2], st_r.modem_control[0], st_r.modem_control[1]}  // RULE17
                             : {~carrier_detect_in_n_i, ~ring_indicator_in_n_i,
                                ~dsr_n_i, ~cts_n_i};

  // Interrupts that this block adds to the rest of the channel.
  assign modem_int = (st_r.msr_delta != 4'h0) && st_r.interrupt_enable[IER_MODEM_BIT];
  assign pending   = !core_isr_i[0] || modem_int
                     || (st_r.spec_flag && st_r.interrupt_enable[IER_PAUSE_BIT]);  // RULE23
  assign isr_val   = {st_r.fifo_control[0], st_r.fifo_control[0], 1'b0, st_r.spec_flag,
                      modem_int && core_isr_i[0] ? 3'h0 : core_isr_i[3:1], ~pending};

  // A start bit, a transmit load or a modem edge restarts the oscillator.
  assign wake = !rx_pin_i  // RULE11
                || (wr_hit && reg_addr_i == OFS_DATA && !st_r.line_control[LCR_DIV_BIT])
                || (modem_now != st_r.modem_prev);

  // Own readiness for sleep; the device sleeps only when all channels agree.
  assign sleep_ok_o = st_r.interrupt_enable[IER_SLEEP_BIT] && !pending  // RULE8
                      && st_r.msr_delta == 4'h0 && rx_pin_i  // RULE9
                      && line_status_i[LSR_TEMT_BIT];

  // ==========================================================================
  // Next state.
  always_comb begin
    st_nxt            = st_r;
    st_nxt.rhr_rd     = 1'b0;
    st_nxt.thr_ld     = 1'b0;
    st_nxt.push       = 1'b0;
    st_nxt.pause_send = 1'b0;
    st_nxt.modem_prev = modem_now;

    // Register writes.
    if (wr_hit) begin
      unique case (reg_addr_i)
        OFS_DATA: begin
          if (st_r.line_control[LCR_DIV_BIT]) begin
            st_nxt.dll = reg_wdata_i;  // RULE20
          end else begin
            st_nxt.thr_ld   = 1'b1;  // RULE19
            st_nxt.thr_data = reg_wdata_i;
          end
        end
        OFS_IER: begin
          if (st_r.line_control[LCR_DIV_BIT]) begin
            st_nxt.divisor_high = reg_wdata_i;
          end else begin
            st_nxt.interrupt_enable = reg_wdata_i;
          end
        end
        OFS_ISR: begin
          if (enh_bank) begin
            st_nxt.enhanced_feature = reg_wdata_i;  // RULE21
          end else if (div_bank) begin
            st_nxt.divisor_fraction = reg_wdata_i;
          end else begin
            st_nxt.fifo_control = reg_wdata_i;
          end
        end
        OFS_LCR: st_nxt.line_control = reg_wdata_i;
        OFS_MCR: begin
          if (enh_bank) begin
            st_nxt.xon1 = reg_wdata_i;
          end else begin
            st_nxt.modem_control = reg_wdata_i;
          end
        end
        OFS_LSR: begin
          if (enh_bank) begin
            st_nxt.xon2 = reg_wdata_i;
          end
        end
        OFS_MSR: begin
          if (enh_bank) begin
            st_nxt.xoff1 = reg_wdata_i;
          end
        end
        OFS_SPR: begin
          if (enh_bank) begin
            st_nxt.xoff2 = reg_wdata_i;
          end else begin
            st_nxt.scratch_pad = reg_wdata_i;
          end
        end
      endcase
    end

    // Register reads, with their side effects.
    if (rd_hit) begin
      unique case (reg_addr_i)
        OFS_DATA: begin
          st_nxt.rdata  = st_r.line_control[LCR_DIV_BIT] ? st_r.dll : rx_holding_i;
          st_nxt.rhr_rd = !st_r.line_control[LCR_DIV_BIT];  // RULE19
        end
        OFS_IER: st_nxt.rdata = st_r.line_control[LCR_DIV_BIT] ? st_r.divisor_high : st_r.interrupt_enable;
        OFS_ISR: begin
          st_nxt.rdata = enh_bank ? st_r.enhanced_feature : (div_bank ? st_r.divisor_fraction : isr_val);
          if (!st_r.line_control[LCR_DIV_BIT]) begin
            st_nxt.spec_flag = 1'b0;
          end
        end
        OFS_LCR: st_nxt.rdata = st_r.line_control;
        OFS_MCR: st_nxt.rdata = enh_bank ? st_r.xon1 : st_r.modem_control;
        OFS_LSR: st_nxt.rdata = enh_bank ? st_r.xon2 : line_status_i;
        OFS_MSR: begin
          st_nxt.rdata = enh_bank ? st_r.xoff1 : {modem_now, st_r.msr_delta};
          if (!enh_bank) begin
            st_nxt.msr_delta = 4'h0;  // RULE13
          end
        end
        OFS_SPR: st_nxt.rdata = enh_bank ? st_r.xoff2 : st_r.scratch_pad;
      endcase
    end

    // Modem change flags; a change in the clearing cycle still sets them.
    st_nxt.msr_delta = st_nxt.msr_delta | (modem_now ^ st_r.modem_prev);

    // Every received character is stored, matched or not.
    if (rx_char_valid_i) begin
      st_nxt.push      = 1'b1;  // RULE2
      st_nxt.push_data = rx_char_i;
      if (st_r.enhanced_feature[EFR_SPEC_BIT] && spec_match) begin  // RULE1
        st_nxt.spec_flag = 1'b1;  // RULE2
      end
    end

    // Sleep control; clearing the sleep enable wakes the device for good.
    if (wake || !st_r.interrupt_enable[IER_SLEEP_BIT]) begin
      st_nxt.asleep = 1'b0;  // RULE14
    end else if (sleep_ok_o && others_sleep_ok_i) begin
      st_nxt.asleep = 1'b1;  // RULE12
    end

    // Pause character after two character times above the trigger.
    unique case (st_r.pause_st)
      UAUX_PS_IDLE: begin
        if (rx_trigger_i && st_r.enhanced_feature[3:2] != 2'h0) begin
          st_nxt.pause_st  = UAUX_PS_WAIT;
          st_nxt.pause_cnt = 9'(PAUSE_CHARS * 16 * uaux_frame_bits(st_r.line_control));  // RULE22
        end
      end
      UAUX_PS_WAIT: begin
        if (!rx_trigger_i) begin
          st_nxt.pause_st = UAUX_PS_IDLE;
        end else if (st_r.pause_cnt == 9'h0) begin
          st_nxt.pause_send = 1'b1;  // RULE22
          st_nxt.pause_st   = UAUX_PS_SENT;
        end else if (tick16_i) begin
          st_nxt.pause_cnt = st_r.pause_cnt - 9'h1;
        end
      end
      UAUX_PS_SENT: begin
        if (!rx_trigger_i) begin
          st_nxt.pause_st = UAUX_PS_IDLE;
        end
      end
      default: st_nxt.pause_st = UAUX_PS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r          <= '0;
      st_r.pause_st <= UAUX_PS_IDLE;
      st_r.line_control      <= REG_RST;
      st_r.xoff2    <= REG_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Line path. The infrared codec sits between shift registers and pins.
  assign ir_bus.tick16    = tick16_i;
  assign ir_bus.bit_start = tx_bit_start_i;
  assign ir_bus.ir_en     = st_r.modem_control[MCR_IR_BIT];  // RULE6
  assign ir_bus.tx_bit    = tx_shift_bit_i;
  assign ir_bus.ir_rx     = rx_pin_i;

  // Loopback holds the pin high, idle to a wired far end but lit to an infrared one.
  assign tx_pin_o    = loop_on ? 1'b1 : (ir_bus.ir_en ? ir_bus.ir_tx : tx_shift_bit_i);  // RULE17
  assign rx_serial_o = loop_on ? tx_shift_bit_i  // RULE16
                               : (ir_bus.ir_en ? ir_bus.rx_bit : rx_pin_i);  // RULE7
  assign rts_n_o     = loop_on || !st_r.modem_control[1];  // RULE17
  assign dtr_n_o     = loop_on || !st_r.modem_control[0];

  // The oscillator restarts in the same cycle as a wake event.
  assign osc_run_o         = !st_r.asleep || wake;  // RULE10
  assign intr_o            = pending;  // RULE23
  assign reg_rdata_o       = st_r.rdata;
  assign rx_holding_rd_o   = st_r.rhr_rd;
  assign tx_holding_ld_o   = st_r.thr_ld;
  assign tx_holding_data_o = st_r.thr_data;
  assign rx_fifo_push_o    = st_r.push;
  assign rx_fifo_data_o    = st_r.push_data;
  assign pause_send_o      = st_r.pause_send;

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_match_rx;
    rx_char_valid_i && st_r.enhanced_feature[EFR_SPEC_BIT] && spec_match;
  endsequence

  AST_SPEC_SETS_FLAG: assert property (s_match_rx |=> st_r.spec_flag)  // RULE1
    else $error("Special character match did not set the flag.");
  AST_SPEC_STORED: assert property (  // RULE2
    rx_char_valid_i |=> rx_fifo_push_o && rx_fifo_data_o == $past(rx_char_i))
    else $error("Received character not stored.");
  AST_WORDLEN_MASK: assert property (  // RULE3
    st_r.line_control[1:0] == 2'h0 && (rx_char_i[4:0] == st_r.xoff2[4:0]) |-> spec_match)
    else $error("Five bit compare looked at upper bits.");
  AST_NO_SLEEP_PENDING: assert property (pending |=> !st_r.asleep || $past(st_r.asleep))  // RULE12
    else $error("Entered sleep with an interrupt pending.");
  AST_OSC_HALT: assert property (st_r.asleep && !wake |-> !osc_run_o)  // RULE10
    else $error("Oscillator running while asleep.");
  AST_WAKE_THR: assert property (  // RULE11
    st_r.asleep && wr_hit && reg_addr_i == OFS_DATA && !st_r.line_control[7] |-> osc_run_o ##1 !st_r.asleep)
    else $error("Transmit load did not wake the device.");
  AST_SLEEP_DISABLE: assert property (!st_r.interrupt_enable[IER_SLEEP_BIT] |=> !st_r.asleep)  // RULE14
    else $error("Asleep with sleep disabled.");
  AST_LOOP_PINS: assert property (loop_on |-> tx_pin_o && rts_n_o && dtr_n_o)  // RULE17
    else $error("Loopback pins not at idle.");
  AST_LOOP_PATH: assert property (loop_on |-> rx_serial_o == tx_shift_bit_i)  // RULE16
    else $error("Loopback path broken.");
  AST_ENH_WRITE: assert property (  // RULE21
    enh_bank && wr_hit && reg_addr_i == OFS_SPR |=> st_r.xoff2 == $past(reg_wdata_i))
    else $error("Pause character 2 write lost.");
  AST_PAUSE_DELAY: assert property (  // RULE22
    st_r.pause_st == UAUX_PS_IDLE ##1 st_r.pause_st == UAUX_PS_WAIT |-> !pause_send_o [*3])
    else $error("Pause character sent too early.");
  AST_PAUSE_IRQ_MASK: assert property (  // RULE23
    core_isr_i[0] && st_r.msr_delta == 4'h0 && !st_r.interrupt_enable[IER_PAUSE_BIT] |-> !intr_o)
    else $error("Special flag interrupt while masked.");
endmodule
`default_nettype wire

/* verilog/uaux_char_match.sv */
// Compares a received character with a stored one over the word length.
// Assumes the character and the stored value are both aligned at bit 0.
`timescale 1ns/10ps
`default_nettype none
module uaux_char_match
  import uaux_pkg::*;
#(
  parameter int W = 8
)
(
  input  wire logic [W-1:0] rx_char_i,
  input  wire logic [W-1:0] stored_i,
  input  wire logic [1:0]   word_len_i,
  output logic              match_o
);

  // ==========================================================================
  // Bits above the word length are ignored; bit 0 meets bit 0.
  logic [W-1:0] mask;
  assign mask    = W'(uaux_len_mask(word_len_i));  // RULE3
  assign match_o = ((rx_char_i ^ stored_i) & mask) == '0;  // RULE4
endmodule
`default_nettype wire

/* verilog/uaux_ir_codec.sv */
// Infrared pulse encoder and decoder of one channel.
// Assumes tick16 pulses sixteen times per bit period.
`timescale 1ns/10ps
`default_nettype none
module uaux_ir_codec
  import uaux_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic reset_n_i,
  uaux_ir_if.codec  ir
);

  typedef struct packed {
    logic [1:0] enc_cnt;
    logic [4:0] dec_cnt;
  } uaux_ir_s;

  uaux_ir_s st_r;
  uaux_ir_s st_nxt;

  // ==========================================================================
  // Encoder and decoder counters.
  always_comb begin
    st_nxt = st_r;
    if (!ir.ir_en) begin
      st_nxt = '0;  // RULE6
    end else begin
      if (ir.bit_start && !ir.tx_bit) begin
        st_nxt.enc_cnt = IR_PULSE_TICK;  // RULE5
      end else if (ir.tick16 && st_r.enc_cnt != 2'h0) begin
        st_nxt.enc_cnt = st_r.enc_cnt - 2'h1;
      end
      // A pulse anywhere in the bit reads as a zero for a full bit period.
      if (ir.ir_rx) begin
        st_nxt.dec_cnt = IR_BIT_TICK;  // RULE24
      end else if (ir.tick16 && st_r.dec_cnt != 5'h0) begin
        st_nxt.dec_cnt = st_r.dec_cnt - 5'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pulse high only while counting, so the line idles low.
  assign ir.ir_tx  = (st_r.enc_cnt != 2'h0);  // RULE7
  assign ir.rx_bit = (st_r.dec_cnt == 5'h0);  // RULE24

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_IR_ZERO_PULSE: assert property (  // RULE5
    ir.ir_en && ir.bit_start && !ir.tx_bit |=> ir.ir_tx)
    else $error("No infrared pulse after a zero bit.");
  AST_IR_OFF_QUIET: assert property (  // RULE6
    !ir.ir_en |=> !ir.ir_tx && ir.rx_bit)
    else $error("Infrared codec active while disabled.");
endmodule
`default_nettype wire

/* verilog/uaux_ir_if.sv */
// Signals between the channel core and its infrared encoder and decoder.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/10ps
`default_nettype none
interface uaux_ir_if;
  logic tick16;     // 16x bit tick.
  logic bit_start;  // First tick of each transmitted bit.
  logic ir_en;      // Infrared mode enabled.
  logic tx_bit;     // Transmit shift register output.
  logic ir_tx;      // Encoded pulse to the pin.
  logic ir_rx;      // Raw pulse from the pin.
  logic rx_bit;     // Decoded serial bit.
  modport core  (output tick16, bit_start, ir_en, tx_bit, ir_rx, input ir_tx, rx_bit);
  modport codec (input tick16, bit_start, ir_en, tx_bit, ir_rx, output ir_tx, rx_bit);
endinterface
`default_nettype wire

/* verilog/uaux_pkg.sv */
// Constants shared by the auxiliary logic of one serial channel.
// Assumes a 50 MHz core clock and a 16x bit tick from the baud generator.
package uaux_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [2:0] OFS_DATA   = 3'h0;  // rx_holding, tx_holding, divisor_low
  localparam logic [2:0] OFS_IER    = 3'h1;  // interrupt_enable, divisor_high
  localparam logic [2:0] OFS_ISR    = 3'h2;  // interrupt_status, fifo_control, fraction, efr
  localparam logic [2:0] OFS_LCR    = 3'h3;
  localparam logic [2:0] OFS_MCR    = 3'h4;  // modem_control, resume_char_1
  localparam logic [2:0] OFS_LSR    = 3'h5;  // line_status, resume_char_2
  localparam logic [2:0] OFS_MSR    = 3'h6;  // modem_status, pause_char_1
  localparam logic [2:0] OFS_SPR    = 3'h7;  // scratch_pad, pause_char_2

  // ==========================================================================
  // Field positions and key values
  localparam logic [7:0] LCR_ENH_KEY   = 8'hbf;
  localparam int         LCR_DIV_BIT   = 7;
  localparam int         EFR_SPEC_BIT  = 5;
  localparam int         IER_SLEEP_BIT = 4;
  localparam int         IER_PAUSE_BIT = 5;
  localparam int         IER_MODEM_BIT = 3;
  localparam int         MCR_LOOP_BIT  = 4;
  localparam int         MCR_IR_BIT    = 6;
  localparam int         ISR_SPEC_BIT  = 4;
  localparam int         LSR_TEMT_BIT  = 6;

  // ==========================================================================
  // Reset values and counts
  localparam logic [7:0] REG_RST       = 8'h00;
  localparam logic [1:0] IR_PULSE_TICK = 2'h3;   // 3/16 of a bit.
  localparam logic [4:0] IR_BIT_TICK   = 5'h10;  // 16 ticks per bit.
  localparam int         PAUSE_CHARS   = 2;

  typedef enum logic [1:0] {
    UAUX_PS_IDLE = 2'b00,
    UAUX_PS_WAIT = 2'b01,
    UAUX_PS_SENT = 2'b11
  } uaux_pause_e;

  // Mask of the compared bits for the word length code in line_control[1:0].
  function automatic logic [7:0] uaux_len_mask(input logic [1:0] wl);
    uaux_len_mask = 8'hff >> (2'h3 - wl);
  endfunction

  // Bits in one character frame: start, data, parity, stop.
  function automatic logic [3:0] uaux_frame_bits(input logic [7:0] line_control);
    uaux_frame_bits = 4'h7 + {2'h0, line_control[1:0]} + {3'h0, line_control[3]} + {3'h0, line_control[2]};
  endfunction

endpackage
